// File: core/mch_handler.sv
// Measurement command handler: decoded measurement commands in, answers out.
// Assumes a parser ahead of it that presents one decoded command per strobe.
// Summary of operation
// - Window suffix must always be one
// - Measure equals configure then read
// - Read equals initiate then fetch
// - Resolution only steers auto averaging
// - Config query returns function and three fields
// - Expected value from last configure, else +20
// - Reset: AC power, +20, res 3, ch 1
// - Configure never starts a measurement
// - Configure forces trigger and averaging defaults
// - Resolution accepted only from one to four
// - Source list must be channel one only
// - Positional params; DEF keeps current value
// - Omitted resolution keeps held value
// - Result invalid on reset, initiate, sense change
// - Fetch stalls while acquisition pending
// - Stale fetch raises -230, no result
// - Mismatched fetch params raise -221
// - External trigger fetch blocks until trigger
// - Device clear aborts, idles, flushes buffers
`timescale 1ns/1ps
`include "mch_params.svh"
module mch_handler (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [2:0] cmd_code,
    input wire logic [3:0] cmd_window,
    input wire logic exp_given,
    input wire logic signed [15:0] exp_value,
    input wire logic res_given,
    input wire logic [2:0] res_value,
    input wire logic chan_given,
    input wire logic [3:0] chan_value,
    input wire logic dev_clear,
    input wire logic sense_changed,
    input wire logic ext_trig_sel,
    input wire logic ext_trig,
    input wire logic acq_done,
    input wire logic [31:0] acq_data,
    output logic acq_start,
    output logic acq_abort,
    output logic buf_flush,
    output logic cont_init,
    output logic trig_src_ext,
    output logic trig_delay_auto,
    output logic avg_count_auto,
    output logic avg_enable,
    output logic [2:0] avg_res,
    output logic resp_valid,
    output logic [31:0] resp_data,
    output logic conf_valid,
    output logic [7:0] conf_func,
    output logic signed [15:0] conf_exp,
    output logic [2:0] conf_res,
    output logic [3:0] conf_chan,
    output logic err_pop,
    output logic [15:0] err_code,
    output logic err_empty,
    input wire logic err_read
);
    typedef enum logic [2:0] {ST_IDLE, ST_WAIT_TRIG, ST_ACQ, ST_FETCH_WAIT} mch_st_t;
    mch_st_t st_r, st_nxt;
    logic signed [15:0] exp_r, exp_nxt, dexp_r, dexp_nxt;
    logic [2:0] res_r, res_nxt, dres_r, dres_nxt;
    logic valid_r, valid_nxt, pend_fetch_r, pend_fetch_nxt;
    logic trig_src_r, trig_src_nxt, cont_r, cont_nxt, dly_r, dly_nxt;
    logic avgc_r, avgc_nxt, avge_r, avge_nxt;
    logic [31:0] data_r, data_nxt;
    logic resp_r, resp_nxt, confv_r, confv_nxt, start_r, start_nxt;
    logic err_push;
    logic [15:0] err_push_code;
    logic take;
    logic bad_args, res_bad;
    logic signed [15:0] arg_exp;
    logic [2:0] arg_res;
    mch_pkg::mch_cmd_t cmd;

    assign cmd = mch_pkg::mch_cmd_t'(cmd_code);
    // A stalled fetch holds off further commands
    assign cmd_ready = !pend_fetch_r && !dev_clear;
    assign take = cmd_valid && cmd_ready;
    assign res_bad = res_given && (res_value < `MCH_RES_MIN || res_value > `MCH_RES_MAX);
    assign bad_args = (cmd_window != `MCH_WINDOW_ONE) ||
        (chan_given && chan_value != `MCH_CHAN_ONE) || res_bad;
    // DEF or omitted leaves the held value
    assign arg_exp = exp_given ? exp_value : exp_r;
    assign arg_res = res_given ? res_value : res_r;

    always_comb begin
        st_nxt = st_r;
        exp_nxt = exp_r;
        res_nxt = res_r;
        dexp_nxt = dexp_r;
        dres_nxt = dres_r;
        valid_nxt = valid_r;
        pend_fetch_nxt = pend_fetch_r;
        trig_src_nxt = trig_src_r;
        cont_nxt = cont_r;
        dly_nxt = dly_r;
        avgc_nxt = avgc_r;
        avge_nxt = avge_r;
        data_nxt = data_r;
        resp_nxt = 1'b0;
        confv_nxt = 1'b0;
        start_nxt = 1'b0;
        err_push = 1'b0;
        err_push_code = 16'h0000;
        if (ext_trig_sel)
            trig_src_nxt = 1'b1;
        if (sense_changed)
            valid_nxt = 1'b0;
        case (st_r)
            ST_WAIT_TRIG: begin
                if (ext_trig) begin
                    st_nxt = ST_ACQ;
                    start_nxt = 1'b1;
                end
            end
            ST_ACQ: begin
                if (acq_done) begin
                    st_nxt = ST_IDLE;
                    valid_nxt = !sense_changed;
                    data_nxt = acq_data;
                end
            end
            default: ;
        endcase
        // Pending fetch answers once data turns valid
        if (pend_fetch_r && valid_nxt && st_nxt == ST_IDLE) begin
            pend_fetch_nxt = 1'b0;
            resp_nxt = 1'b1;
        end
        if (take) begin
            if (bad_args) begin
                err_push = 1'b1;
                err_push_code = res_bad ? `MCH_ERR_BADPARAM : `MCH_ERR_BADCHAN;
            end else begin
                case (cmd)
                    mch_pkg::MCH_CMD_CONF, mch_pkg::MCH_CMD_MEAS: begin
                        exp_nxt = arg_exp;
                        res_nxt = arg_res;
                        // Configure stores only; measure goes on to read
                        cont_nxt = 1'b0;
                        trig_src_nxt = 1'b0;
                        dly_nxt = 1'b1;
                        avgc_nxt = 1'b1;
                        avge_nxt = 1'b1;
                        valid_nxt = 1'b0;
                        if (cmd == mch_pkg::MCH_CMD_MEAS) begin
                            valid_nxt = 1'b0;
                            dexp_nxt = arg_exp;
                            dres_nxt = arg_res;
                            st_nxt = ST_ACQ;
                            start_nxt = 1'b1;
                            pend_fetch_nxt = 1'b1;
                        end
                    end
                    mch_pkg::MCH_CMD_CONF_Q: confv_nxt = 1'b1;
                    mch_pkg::MCH_CMD_INIT, mch_pkg::MCH_CMD_READ: begin
                        valid_nxt = 1'b0;
                        dexp_nxt = exp_r;
                        dres_nxt = res_r;
                        st_nxt = trig_src_r ? ST_WAIT_TRIG : ST_ACQ;
                        start_nxt = !trig_src_r;
                        pend_fetch_nxt = (cmd == mch_pkg::MCH_CMD_READ);
                    end
                    mch_pkg::MCH_CMD_FETCH: begin
                        if ((exp_given && exp_value != dexp_r) ||
                            (res_given && res_value != dres_r)) begin
                            err_push = 1'b1;
                            err_push_code = `MCH_ERR_CONFLICT;
                        end else if (valid_r) begin
                            resp_nxt = 1'b1;
                        end else if (st_r == ST_IDLE) begin
                            err_push = 1'b1;
                            err_push_code = `MCH_ERR_STALE;
                        end else begin
                            pend_fetch_nxt = 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
        end
        if (dev_clear) begin
            st_nxt = ST_IDLE;
            pend_fetch_nxt = 1'b0;
            resp_nxt = 1'b0;
            confv_nxt = 1'b0;
            start_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            st_r <= ST_IDLE;
            exp_r <= `MCH_EXP_RST;
            res_r <= `MCH_RES_RST;
            dexp_r <= `MCH_EXP_RST;
            dres_r <= `MCH_RES_RST;
            valid_r <= 1'b0;
            pend_fetch_r <= 1'b0;
            trig_src_r <= 1'b0;
            cont_r <= 1'b0;
            dly_r <= 1'b1;
            avgc_r <= 1'b1;
            avge_r <= 1'b1;
            data_r <= 32'h0000_0000;
            resp_r <= 1'b0;
            confv_r <= 1'b0;
            start_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            exp_r <= exp_nxt;
            res_r <= res_nxt;
            dexp_r <= dexp_nxt;
            dres_r <= dres_nxt;
            valid_r <= valid_nxt;
            pend_fetch_r <= pend_fetch_nxt;
            trig_src_r <= trig_src_nxt;
            cont_r <= cont_nxt;
            dly_r <= dly_nxt;
            avgc_r <= avgc_nxt;
            avge_r <= avge_nxt;
            data_r <= data_nxt;
            resp_r <= resp_nxt;
            confv_r <= confv_nxt;
            start_r <= start_nxt;
        end
    end

    assign acq_start = start_r;
    assign acq_abort = dev_clear;
    assign buf_flush = dev_clear;
    assign cont_init = cont_r;
    assign trig_src_ext = trig_src_r;
    assign trig_delay_auto = dly_r;
    assign avg_count_auto = avgc_r;
    assign avg_enable = avge_r;
    assign avg_res = res_r;
    assign resp_valid = resp_r;
    assign resp_data = data_r;
    assign conf_valid = confv_r;
    assign conf_func = `MCH_FUNC_AC_POWER;
    assign conf_exp = exp_r;
    assign conf_res = res_r;
    assign conf_chan = `MCH_CHAN_ONE;
    assign err_pop = err_read && !err_empty;

    mch_errq u_errq (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .push(err_push),
        .push_code(err_push_code),
        .pop(err_read),
        .head_code(err_code),
        .empty(err_empty),
        .full()
    );

    a_stale_fetch_err: assert property (@(posedge core_clk) disable iff (!rst_n)
        take && cmd == mch_pkg::MCH_CMD_FETCH && !bad_args && !valid_r && st_r == ST_IDLE &&
        !(exp_given && exp_value != dexp_r) && !(res_given && res_value != dres_r)
        |-> err_push && err_push_code == `MCH_ERR_STALE ##1 !resp_valid)
        else $error("stale fetch did not raise -230");
    a_conf_no_start: assert property (@(posedge core_clk) disable iff (!rst_n)
        take && cmd == mch_pkg::MCH_CMD_CONF |-> ##1 !acq_start)
        else $error("configure started a measurement");
    a_conf_defaults: assert property (@(posedge core_clk) disable iff (!rst_n)
        take && cmd == mch_pkg::MCH_CMD_CONF && !bad_args && !dev_clear |-> ##1
        !cont_init && !trig_src_ext && trig_delay_auto && avg_count_auto && avg_enable)
        else $error("configure did not force defaults");
    a_read_starts: assert property (@(posedge core_clk) disable iff (!rst_n)
        take && cmd == mch_pkg::MCH_CMD_READ && !bad_args && !trig_src_r && !dev_clear
        |-> ##1 acq_start && !cmd_ready)
        else $error("read did not initiate");
    a_res_keep: assert property (@(posedge core_clk) disable iff (!rst_n)
        take && cmd == mch_pkg::MCH_CMD_CONF && !res_given && !dev_clear
        |-> ##1 conf_res == $past(res_r))
        else $error("omitted resolution changed");
    a_bad_chan: assert property (@(posedge core_clk) disable iff (!rst_n)
        take && chan_given && chan_value != `MCH_CHAN_ONE |-> err_push ##1 $stable(conf_exp))
        else $error("bad channel accepted");
    a_conflict_err: assert property (@(posedge core_clk) disable iff (!rst_n)
        take && cmd == mch_pkg::MCH_CMD_FETCH && !bad_args && res_given && res_value != dres_r
        |-> err_push && err_push_code == `MCH_ERR_CONFLICT)
        else $error("conflict not raised");
    a_clear_idle: assert property (@(posedge core_clk) disable iff (!rst_n)
        dev_clear |-> ##1 st_r == ST_IDLE && !pend_fetch_r && !resp_valid)
        else $error("device clear did not idle");
    a_fetch_answer: assert property (@(posedge core_clk) disable iff (!rst_n)
        take && cmd == mch_pkg::MCH_CMD_FETCH && !bad_args && valid_r &&
        !(exp_given && exp_value != dexp_r) && !(res_given && res_value != dres_r)
        |-> ##1 resp_valid && resp_data == $past(data_r))
        else $error("valid fetch did not answer");
    a_conf_answer: assert property (@(posedge core_clk) disable iff (!rst_n)
        take && cmd == mch_pkg::MCH_CMD_CONF_Q && !bad_args |-> ##1 conf_valid &&
        conf_func == `MCH_FUNC_AC_POWER && conf_chan == `MCH_CHAN_ONE)
        else $error("configuration query not answered");
    a_fetch_stall: assert property (@(posedge core_clk) disable iff (!rst_n)
        pend_fetch_r && !valid_r |-> !cmd_ready && !resp_valid)
        else $error("stalled fetch let a command or answer through");
endmodule // mch_handler

// File: core/mch_params.svh
// Constants of the measurement command handler: codes, reset values, limits, queue size.
// Assumes inclusion by the handler's modules and bench.
`ifndef MCH_PARAMS_SVH
`define MCH_PARAMS_SVH

`define MCH_WINDOW_ONE 4'h1
`define MCH_CHAN_ONE 4'h1
`define MCH_EXP_RST 16'sh0014
`define MCH_RES_RST 3'h3
`define MCH_RES_MIN 3'h1
`define MCH_RES_MAX 3'h4
`define MCH_ERR_STALE 16'shff1a
`define MCH_ERR_CONFLICT 16'shff23
`define MCH_ERR_BADCHAN 16'shff26
`define MCH_ERR_BADPARAM 16'shff24
`define MCH_ERRQ_DEPTH 8
`define MCH_ERRQ_AW 3
`define MCH_FUNC_AC_POWER 8'h01

`endif

// File: core/mch_pkg.sv
// Types of the measurement command handler.
// Constants live in mch_params.svh.
package mch_pkg;
    typedef enum logic [2:0] {
        MCH_CMD_CONF,
        MCH_CMD_CONF_Q,
        MCH_CMD_INIT,
        MCH_CMD_FETCH,
        MCH_CMD_READ,
        MCH_CMD_MEAS
    } mch_cmd_t;
endpackage

// File: core/mch_errq.sv
// Error queue of the handler: small FIFO of 16-bit codes.
// Assumes one push and one pop port in the core_clk domain.
`timescale 1ns/1ps
`include "mch_params.svh"
module mch_errq (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic push,
    input wire logic [15:0] push_code,
    input wire logic pop,
    output logic [15:0] head_code,
    output logic empty,
    output logic full
);
    logic [15:0] mem_r [`MCH_ERRQ_DEPTH];
    logic [`MCH_ERRQ_AW:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [15:0] head_r;
    logic do_push, do_pop;

    assign empty = (wp_r == rp_r);
    assign full = (wp_r[`MCH_ERRQ_AW] != rp_r[`MCH_ERRQ_AW]) &&
        (wp_r[`MCH_ERRQ_AW-1:0] == rp_r[`MCH_ERRQ_AW-1:0]);
    assign do_push = push && !full;
    assign do_pop = pop && !empty;
    assign head_code = head_r;

    always_comb begin
        wp_nxt = wp_r + {{`MCH_ERRQ_AW{1'b0}}, do_push};
        rp_nxt = rp_r + {{`MCH_ERRQ_AW{1'b0}}, do_pop};
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            wp_r <= '0;
            rp_r <= '0;
            head_r <= 16'h0000;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            // Registered head; a push into an empty queue shows next cycle
            if (wp_nxt == rp_nxt)
                head_r <= 16'h0000;
            else if (do_push && (wp_r == rp_nxt))
                head_r <= push_code;
            else
                head_r <= mem_r[rp_nxt[`MCH_ERRQ_AW-1:0]];
        end
    end

    always_ff @(posedge core_clk) begin
        if (do_push)
            mem_r[wp_r[`MCH_ERRQ_AW-1:0]] <= push_code;
    end
endmodule // mch_errq

// File: sim/mch_acq_model.sv
// Acquisition front end model: answers acq_start with one acq_done pulse.
// Assumes the handler's core_clk domain; the bench sets the answer delay.
`timescale 1ns/1ps
module mch_acq_model (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic acq_start,
    input wire logic acq_abort,
    input wire logic [7:0] delay,
    output logic acq_done,
    output logic [31:0] acq_data
);
    logic pend;
    logic [7:0] cnt;
    logic [31:0] val = 32'h1234_5678;
    // Inverse outside the pulse so stale data never looks valid
    assign acq_data = acq_done ? val : ~val;
    // The handler waits for the trigger itself; a start means acquire now
    always @(posedge core_clk) begin
        if (!rst_n || acq_abort) begin
            pend <= 1'h0;
            acq_done <= 1'h0;
        end else if (acq_start) begin
            pend <= 1'h1;
            cnt <= delay;
            acq_done <= 1'h0;
        end else if (pend && cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
            acq_done <= 1'h0;
        end else if (pend) begin
            pend <= 1'h0;
            acq_done <= 1'h1;
            val <= val + 32'h0101_0101;
        end else begin
            acq_done <= 1'h0;
        end
    end
endmodule // mch_acq_model

// File: sim/mch_handler_tb.sv
// Bench of the measurement command handler, acting as the host.
// Assumes mch_pkg compiled first and mch_params.svh on the include path.
`timescale 1ns/1ps
`include "mch_params.svh"
module mch_handler_tb;
    logic core_clk, rst_n = 1'h0, cmd_valid = 1'h0, exp_given = 1'h0, res_given = 1'h0;
    logic chan_given = 1'h0, dev_clear = 1'h0, sense_changed = 1'h0, ext_trig_sel = 1'h0;
    logic ext_trig = 1'h0, err_read = 1'h0, cmd_ready, acq_done, acq_start, acq_abort;
    logic buf_flush, cont_init, trig_src_ext, trig_delay_auto, avg_count_auto, avg_enable;
    logic resp_valid, conf_valid, err_pop, err_empty;
    logic [2:0] cmd_code = 3'h0, res_value = 3'h0, avg_res, conf_res;
    logic [3:0] cmd_window = 4'h1, chan_value = 4'h1, conf_chan;
    logic signed [15:0] exp_value = 16'sh0000, conf_exp;
    logic [31:0] acq_data, resp_data, nacq = 32'h0, nstart = 32'h0;
    logic [7:0] conf_func, delay = 8'h05;
    logic [15:0] err_code;
    int failures = 0, comparisons = 0;
    mch_handler mch_handler_inst (.core_clk, .rst_n, .cmd_valid, .cmd_ready, .cmd_code,
        .cmd_window, .exp_given, .exp_value, .res_given, .res_value, .chan_given,
        .chan_value, .dev_clear, .sense_changed, .ext_trig_sel, .ext_trig, .acq_done,
        .acq_data, .acq_start, .acq_abort, .buf_flush, .cont_init, .trig_src_ext,
        .trig_delay_auto, .avg_count_auto, .avg_enable, .avg_res, .resp_valid, .resp_data,
        .conf_valid, .conf_func, .conf_exp, .conf_res, .conf_chan, .err_pop, .err_code,
        .err_empty, .err_read);
    mch_acq_model mch_acq_model_inst (.core_clk, .rst_n, .acq_start, .acq_abort,
        .delay, .acq_done, .acq_data);
    always @(posedge core_clk) if (acq_start === 1'h1) nstart <= nstart + 32'h1;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic send(input logic [2:0] c, input logic [3:0] w, input logic eg,
        input logic [15:0] ev, input logic rg, input logic [2:0] rv, input logic [3:0] cv);
        cmd_valid <= 1'h1;
        cmd_code <= c;
        cmd_window <= w;
        exp_given <= eg;
        exp_value <= ev;
        res_given <= rg;
        res_value <= rv;
        chan_given <= cv != 4'h0;
        chan_value <= cv;
        @(negedge core_clk);
        for (int i = 0; i < 200 && cmd_ready !== 1'h1; i++) @(negedge core_clk);
        chk({31'h0, cmd_ready}, 32'h1);
        @(posedge core_clk);
        cmd_valid <= 1'h0;
    endtask
    task automatic simple(input logic [2:0] c);
        send(c, 4'h1, 1'h0, 16'h0, 1'h0, 3'h0, 4'h0);
    endtask
    task automatic get_resp(input int n);
        @(negedge core_clk);
        for (int i = 0; i < n && resp_valid !== 1'h1; i++) @(negedge core_clk);
        chk({31'h0, resp_valid}, 32'h1);
        chk(resp_data, 32'h1234_5678 + nacq * 32'h0101_0101);
        @(posedge core_clk);
    endtask
    task automatic chk_conf(input logic [15:0] e, input logic [2:0] r);
        simple(mch_pkg::MCH_CMD_CONF_Q);
        @(negedge core_clk);
        for (int i = 0; i < 8 && conf_valid !== 1'h1; i++) @(negedge core_clk);
        chk({31'h0, conf_valid}, 32'h1);
        chk({conf_func, conf_exp, 1'h0, conf_res, conf_chan},
            {`MCH_FUNC_AC_POWER, e, 1'h0, r, 4'h1});
        @(posedge core_clk);
    endtask
    task automatic chk_err(input logic [15:0] e);
        repeat (2) @(negedge core_clk);
        chk({15'h0, err_empty, err_code}, {16'h0, e});
        @(posedge core_clk);
        err_read <= 1'h1;
        @(negedge core_clk);
        chk({31'h0, err_pop}, 32'h1);
        @(posedge core_clk);
        err_read <= 1'h0;
    endtask
    task automatic chk_lvl(input logic ext, input logic [2:0] r);
        chk({24'h0, cont_init, trig_src_ext, trig_delay_auto, avg_count_auto, avg_enable, avg_res},
            {24'h0, 1'h0, ext, 3'h7, r});
    endtask
    task automatic s_conf();
        logic [31:0] s0;
        s0 = nstart;
        send(mch_pkg::MCH_CMD_CONF, 4'h1, 1'h1, 16'hfffb, 1'h1, 3'h2, 4'h1);
        repeat (6) @(posedge core_clk);
        chk(nstart, s0);
        chk_lvl(1'h0, 3'h2);
        send(mch_pkg::MCH_CMD_CONF, 4'h1, 1'h0, 16'h0, 1'h0, 3'h0, 4'h0);
        @(posedge core_clk);
        chk_conf(16'hfffb, 3'h2);
        send(mch_pkg::MCH_CMD_CONF, 4'h1, 1'h1, 16'h0003, 1'h1, 3'h5, 4'h0);
        @(posedge core_clk);
        send(mch_pkg::MCH_CMD_CONF, 4'h1, 1'h0, 16'h0, 1'h0, 3'h0, 4'h2);
        chk_err(`MCH_ERR_BADPARAM);
        chk_err(`MCH_ERR_BADCHAN);
        chk_conf(16'hfffb, 3'h2);
    endtask
    task automatic s_acq();
        simple(mch_pkg::MCH_CMD_READ);
        nacq++;
        get_resp(40);
        simple(mch_pkg::MCH_CMD_FETCH);
        get_resp(4);
        send(mch_pkg::MCH_CMD_FETCH, 4'h1, 1'h1, 16'h0007, 1'h0, 3'h0, 4'h0);
        chk_err(`MCH_ERR_CONFLICT);
        delay <= 8'h28;
        send(mch_pkg::MCH_CMD_MEAS, 4'h1, 1'h1, 16'h000a, 1'h0, 3'h0, 4'h0);
        nacq++;
        get_resp(80);
        chk_conf(16'h000a, 3'h2);
        delay <= 8'h00;
        simple(mch_pkg::MCH_CMD_INIT);
        nacq++;
        repeat (10) @(posedge core_clk);
        sense_changed <= 1'h1;
        @(posedge core_clk);
        sense_changed <= 1'h0;
        simple(mch_pkg::MCH_CMD_FETCH);
        chk_err(`MCH_ERR_STALE);
    endtask
    task automatic s_ext();
        ext_trig_sel <= 1'h1;
        @(posedge core_clk);
        ext_trig_sel <= 1'h0;
        simple(mch_pkg::MCH_CMD_INIT);
        @(posedge core_clk);
        simple(mch_pkg::MCH_CMD_FETCH);
        repeat (30) @(negedge core_clk);
        chk({30'h0, cmd_ready, resp_valid}, 32'h0);
        @(posedge core_clk);
        dev_clear <= 1'h1;
        @(negedge core_clk);
        chk({30'h0, acq_abort, buf_flush}, 32'h3);
        @(posedge core_clk);
        dev_clear <= 1'h0;
        repeat (2) @(negedge core_clk);
        chk({31'h0, cmd_ready}, 32'h1);
        chk_conf(16'h000a, 3'h2);
        simple(mch_pkg::MCH_CMD_INIT);
        @(posedge core_clk);
        simple(mch_pkg::MCH_CMD_FETCH);
        repeat (10) @(posedge core_clk);
        ext_trig <= 1'h1;
        @(posedge core_clk);
        ext_trig <= 1'h0;
        nacq++;
        get_resp(40);
        send(mch_pkg::MCH_CMD_CONF, 4'h2, 1'h1, 16'h0001, 1'h0, 3'h0, 4'h0);
        chk_err(`MCH_ERR_BADCHAN);
        chk_conf(16'h000a, 3'h2);
        simple(mch_pkg::MCH_CMD_CONF);
        repeat (2) @(negedge core_clk);
        chk_lvl(1'h0, 3'h2);
        chk({31'h0, err_empty}, 32'h1);
    endtask
    task automatic results();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        core_clk = 1'h0;
        forever #2 core_clk = ~core_clk;
    end
    initial begin
        repeat (5000) @(posedge core_clk);
        failures++;
        results();
    end
    initial begin
        repeat (4) @(posedge core_clk);
        rst_n <= 1'h1;
        @(posedge core_clk);
        chk_lvl(1'h0, 3'h3);
        chk_conf(16'h0014, 3'h3);
        simple(mch_pkg::MCH_CMD_FETCH);
        chk_err(`MCH_ERR_STALE);
        s_conf();
        s_acq();
        s_ext();
        results();
    end
endmodule // mch_handler_tb
